// *** src/trvf_pkg.sv ***
package trvf_pkg;

  // ----------------------------------------------------------------
  // timing and sizes
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned DWELL_UNIT_MS  = 1;
  localparam int unsigned DWELL_UNIT_CYC = CLK_HZ / 1000 * DWELL_UNIT_MS;
  localparam int unsigned MEM_DEPTH      = 25;
  localparam int unsigned IDX_W          = $clog2(MEM_DEPTH + 1);
  localparam logic [IDX_W-1:0] MEM_FULL  = IDX_W'(MEM_DEPTH);
  localparam logic [IDX_W-1:0] IDX_ONE   = IDX_W'(1);
  localparam int unsigned STEPS_PER_REV  = 200;
  localparam int unsigned SUB1_SPAN_DEG  = 270;
  localparam int unsigned SUB2_TURNS     = 3;
  localparam int unsigned SUB1_STEPS     = STEPS_PER_REV * SUB1_SPAN_DEG / 360;
  localparam int unsigned SUB2_STEPS     = STEPS_PER_REV * SUB2_TURNS;
  localparam logic [1:0]  RESTORE_LAST   = 2'h2;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_MAXRATE = 5'h04;
  localparam logic [4:0] REG_TEACH   = 5'h08;
  localparam logic [4:0] REG_COUNT   = 5'h0c;
  localparam logic [4:0] REG_REPLAY  = 5'h10;
  localparam logic [4:0] REG_STATUS  = 5'h14;
  localparam logic [4:0] REG_TARGET  = 5'h18;
  localparam logic [4:0] REG_SPEED   = 5'h1c;

  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_SUB_LSB   = 2;
  localparam int unsigned CTRL_STOP_BIT  = 4;
  localparam int unsigned REPLAY_ALL_BIT = 0;
  localparam int unsigned REPLAY_ONE_BIT = 1;
  localparam int unsigned ST_READY_BIT   = 0;
  localparam int unsigned ST_MODE_LSB    = 1;
  localparam int unsigned ST_COUNT_LSB   = 8;
  localparam int unsigned ST_PTR_LSB     = 16;
  localparam int unsigned ST_STATE_LSB   = 24;

  localparam logic [15:0] MAX_RATE_RST   = 16'h0190;
  localparam logic        STOP_POWER_RST = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HOST   = 2'h0,
    MODE_VOLT   = 2'h1,
    MODE_TEACH  = 2'h2,
    MODE_REMOTE = 2'h3
  } trvf_mode_type;

  typedef enum logic [1:0] {
    SUB_NONE  = 2'h0,
    SUB_PROP  = 2'h1,
    SUB_GAIN  = 2'h2,
    SUB_SPEED = 2'h3
  } trvf_sub_type;

  typedef enum logic [3:0] {
    RP_IDLE  = 4'h1,
    RP_ISSUE = 4'h2,
    RP_WAIT  = 4'h4,
    RP_DWELL = 4'h8
  } trvf_state_type;

  typedef struct packed {
    logic        dwell;
    logic [15:0] value;
  } trvf_entry_type;

  typedef struct packed {
    logic               valid;
    logic signed [15:0] target;
    logic signed [16:0] speed;
  } trvf_follow_type;

endpackage

// *** src/trvf_edge.sv ***
`timescale 1ns/1ps
module trvf_edge
  import trvf_pkg::*;
#(
  parameter int unsigned  N    = 2,
  parameter logic [N-1:0] IDLE = '1
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] pin,
  output logic [N-1:0]      level,
  output logic [N-1:0]      fall
);

  // ----------------------------------------------------------------
  // two-stage synchroniser and falling-edge detect per pin
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      logic meta;
      logic sync;
      logic prev;

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta <= IDLE[i];
          sync <= IDLE[i];
          prev <= IDLE[i];
        end
        else
        begin
          meta <= pin[i];
          sync <= meta;
          prev <= sync;
        end
      end

      assign level[i] = sync;
      assign fall[i]  = prev & ~sync;

      fall_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        fall[i] |-> !level[i] ##1 !fall[i])
        else $error("falling edge reported twice or on a rising level");
    end
  endgenerate

endmodule

// *** src/trvf_top.sv ***
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module trvf_top
  import trvf_pkg::*;
#(
  parameter int unsigned ADC_W     = 10,
  parameter int unsigned DWELL_CYC = DWELL_UNIT_CYC,
  parameter bit          PRO_BUILD = 1'b1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [4:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  input  wire logic             replay_all_input,
  input  wire logic             replay_single_input,
  input  wire logic             remote_saved,
  output logic                  remote_store,
  input  wire logic             adc_valid,
  input  wire logic [ADC_W-1:0] adc_data,
  output logic                  cmd_valid,
  output logic [15:0]           cmd_value,
  input  wire logic             cmd_done,
  input  wire logic             motor_moving,
  output logic                  busy_ready,
  output logic [15:0]           max_rate,
  output logic                  stop_power,
  output trvf_follow_type       follow
);

  generate
    if (ADC_W < 8 || ADC_W > 12 || DWELL_CYC < 1 || DWELL_CYC > 65536)
    begin : g_bad_param
      $error("trvf_top: unsupported parameter value");
    end
  endgenerate

  localparam logic [15:0]      DWELL_LAST = 16'(DWELL_CYC - 1);
  localparam logic [ADC_W-1:0] ADC_MID    = {1'b1, {(ADC_W - 1){1'b0}}};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  trvf_mode_type          mode;
  trvf_sub_type           sub;
  trvf_state_type         state;
  trvf_entry_type         mem [MEM_DEPTH];
  trvf_entry_type         cur;
  logic [IDX_W-1:0]       count;
  logic [IDX_W-1:0]       ptr;
  logic [IDX_W-1:0]       remaining;
  logic [15:0]            unit_cnt;
  logic [15:0]            dwell_left;
  logic [1:0]             restore_cnt;
  logic                   restored;
  logic [2:0]             level;
  logic [2:0]             fall;
  logic                   sw_all;
  logic                   sw_one;
  logic                   can_start;
  logic                   go_all;
  logic                   go_one;
  logic                   teach_wr;
  logic                   clear_wr;
  logic                   entry_done;
  logic [ADC_W+9:0]       span1;
  logic [ADC_W+9:0]       span2;
  logic signed [ADC_W:0]  offs;
  logic signed [ADC_W+17:0] prod;
  logic [31:0]            next_rdata;

  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  trvf_edge #(
    .N    (3),
    .IDLE (3'h3)
  ) u_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({remote_saved, replay_single_input, replay_all_input}),
    .level (level),
    .fall  (fall)
  );

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode        <= MODE_HOST;
      sub         <= SUB_PROP;
      restore_cnt <= 2'h0;
      restored    <= 1'b0;
    end
    else if (!restored)
    begin
      restore_cnt <= restore_cnt + 2'h1;
      if (restore_cnt == RESTORE_LAST)
      begin
        restored <= 1'b1;
        if (level[2])
          mode <= MODE_REMOTE;
      end
    end
    else if (reg_wr && reg_addr == REG_CTRL)
    begin
      sub <= trvf_sub_type'(reg_wdata[CTRL_SUB_LSB +: 2]);
      if (PRO_BUILD || trvf_mode_type'(reg_wdata[CTRL_MODE_LSB +: 2]) != MODE_TEACH)
        mode <= trvf_mode_type'(reg_wdata[CTRL_MODE_LSB +: 2]);
    end
  end

  assign remote_store = (mode == MODE_REMOTE);

  // ----------------------------------------------------------------
  // motion settings, written only in host mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      max_rate   <= MAX_RATE_RST;
      stop_power <= STOP_POWER_RST;
    end
    else if (mode == MODE_HOST && reg_wr)
    begin
      if (reg_addr == REG_MAXRATE)
        max_rate <= reg_wdata[15:0];
      if (reg_addr == REG_CTRL)
        stop_power <= reg_wdata[CTRL_STOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // teach memory
  // ----------------------------------------------------------------
  assign teach_wr = reg_wr && reg_addr == REG_TEACH && mode == MODE_TEACH
                    && state == RP_IDLE && count < MEM_FULL;
  assign clear_wr = reg_wr && reg_addr == REG_COUNT && mode == MODE_TEACH
                    && state == RP_IDLE;

  always_ff @(posedge clk)
  begin
    if (teach_wr)
      mem[count] <= reg_wdata[16:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (clear_wr)
      count <= '0;
    else if (teach_wr)
      count <= count + IDX_ONE;
  end

  // ----------------------------------------------------------------
  // replay start
  // ----------------------------------------------------------------
  assign sw_all    = reg_wr && reg_addr == REG_REPLAY && reg_wdata[REPLAY_ALL_BIT]
                     && mode == MODE_HOST;
  assign sw_one    = reg_wr && reg_addr == REG_REPLAY && reg_wdata[REPLAY_ONE_BIT]
                     && mode == MODE_HOST;
  assign can_start = restored && state == RP_IDLE && count != '0;
  assign go_all    = can_start && (sw_all || (fall[0] && mode == MODE_REMOTE));
  assign go_one    = can_start && !go_all
                     && (sw_one || (fall[1] && mode == MODE_REMOTE));

  assign cur        = mem[ptr];
  assign entry_done = (state == RP_WAIT && cmd_done && !cmd_valid)
                      || (state == RP_DWELL && dwell_left == 16'h0000);

  // ----------------------------------------------------------------
  // replay sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= RP_IDLE;
      remaining  <= '0;
      cmd_valid  <= 1'b0;
      cmd_value  <= 16'h0000;
      unit_cnt   <= 16'h0000;
      dwell_left <= 16'h0000;
    end
    else
    begin
      cmd_valid <= 1'b0;
      case (state)
        RP_IDLE:
        begin
          if (go_all)
          begin
            remaining <= count;
            state     <= RP_ISSUE;
          end
          else if (go_one)
          begin
            remaining <= IDX_ONE;
            state     <= RP_ISSUE;
          end
        end
        RP_ISSUE:
        begin
          if (cur.dwell)
          begin
            dwell_left <= cur.value;
            unit_cnt   <= DWELL_LAST;
            state      <= RP_DWELL;
          end
          else
          begin
            cmd_valid <= 1'b1;
            cmd_value <= cur.value;
            state     <= RP_WAIT;
          end
        end
        RP_WAIT, RP_DWELL:
        begin
          if (entry_done)
          begin
            remaining <= remaining - IDX_ONE;
            state     <= (remaining == IDX_ONE) ? RP_IDLE : RP_ISSUE;
          end
          else if (state == RP_DWELL)
          begin
            if (unit_cnt == 16'h0000)
            begin
              unit_cnt   <= DWELL_LAST;
              dwell_left <= dwell_left - 16'h0001;
            end
            else
              unit_cnt <= unit_cnt - 16'h0001;
          end
        end
        default:
          state <= RP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr <= '0;
    else if (entry_done)
      ptr <= (ptr == count - IDX_ONE) ? '0 : ptr + IDX_ONE;
    else if (clear_wr)
      ptr <= '0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_ready <= 1'b1;
    else
      busy_ready <= (state == RP_IDLE) && !motor_moving;
  end

  // ----------------------------------------------------------------
  // voltage follow
  // ----------------------------------------------------------------
  assign span1 = adc_data * 10'(SUB1_STEPS);
  assign span2 = adc_data * 10'(SUB2_STEPS);
  assign offs  = $signed({1'b0, ADC_MID}) - $signed({1'b0, adc_data});
  assign prod  = offs * $signed({1'b0, max_rate});

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      follow <= '0;
    else
    begin
      follow.valid <= mode == MODE_VOLT && adc_valid;
      if (mode == MODE_VOLT && adc_valid)
      begin
        case (sub)
          SUB_PROP:
            follow.target <= $signed({6'h00, span1[ADC_W +: 10]});
          SUB_GAIN:
            follow.target <= $signed({6'h00, span2[ADC_W +: 10]});
          SUB_SPEED:
            follow.speed <= prod[ADC_W - 1 +: 17];
          default:
            follow.speed <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = '0;
    case (reg_addr)
      REG_CTRL:
      begin
        next_rdata[CTRL_MODE_LSB +: 2] = mode;
        next_rdata[CTRL_SUB_LSB +: 2]  = sub;
        next_rdata[CTRL_STOP_BIT]      = stop_power;
      end
      REG_MAXRATE:
        next_rdata[15:0] = max_rate;
      REG_COUNT:
        next_rdata[IDX_W-1:0] = count;
      REG_STATUS:
      begin
        next_rdata[ST_READY_BIT]            = busy_ready;
        next_rdata[ST_MODE_LSB +: 2]        = mode;
        next_rdata[ST_COUNT_LSB +: IDX_W]   = count;
        next_rdata[ST_PTR_LSB +: IDX_W]     = ptr;
        next_rdata[ST_STATE_LSB +: 4]       = state;
      end
      REG_TARGET:
        next_rdata[15:0] = follow.target;
      REG_SPEED:
        next_rdata[16:0] = follow.speed;
      default:
        next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sw_replay_a: assert property (sw_all && can_start |=> state == RP_ISSUE)
    else $error("software replay did not start");
  all_load_a: assert property (go_all |=> remaining == $past(count) ##1 state != RP_IDLE)
    else $error("replay-all did not load the stored count");
  one_load_a: assert property (go_one && !cur.dwell |=> remaining == IDX_ONE
    ##1 cmd_valid ##1 !cmd_valid)
    else $error("replay-single did not issue exactly one command");
  ptr_wrap_a: assert property (entry_done && ptr == count - IDX_ONE |=> ptr == '0)
    else $error("replay pointer did not wrap to the first entry");
  rest_speed_a: assert property (mode == MODE_VOLT && sub == SUB_SPEED && adc_valid
    && adc_data == ADC_MID |=> follow.speed == '0 && follow.valid)
    else $error("mid-scale input did not rest the motor");
  cw_sign_a: assert property (mode == MODE_VOLT && sub == SUB_SPEED && adc_valid
    && adc_data == '0 && max_rate != 16'h0000 |=> follow.speed > 0)
    else $error("zero input did not give clockwise speed");
  rate_hold_a: assert property (mode != MODE_HOST |=> $stable(max_rate)
    && $stable(stop_power))
    else $error("motion settings changed outside host mode");
  no_teach_a: assert property (!PRO_BUILD |-> mode != MODE_TEACH)
    else $error("teach mode entered on a non-professional build");
  busy_low_a: assert property (state != RP_IDLE |=> !busy_ready)
    else $error("busy output high during replay");
  empty_idle_a: assert property (count == '0 && state == RP_IDLE |=> state == RP_IDLE)
    else $error("replay started with no stored entries");

  all_run_c: cover property (go_all ##[1:200] state == RP_IDLE);
  one_run_c: cover property (go_one ##1 state == RP_ISSUE);
  dwell_c: cover property (state == RP_DWELL ##[1:100] entry_done);
  remote_c: cover property (restored && mode == MODE_REMOTE && fall[1]);

endmodule

// *** verif/trvf_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// replay pin controller and motion engine
// ----------------------------------------------------------------
module trvf_host_model
  import trvf_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic go_all,
  input  wire logic go_one,
  input  wire logic cmd_valid,
  output logic      cmd_done,
  output logic      motor_moving,
  output logic      replay_all_input,
  output logic      replay_single_input
);
  logic [3:0] pin_cnt;
  logic [3:0] mv_cnt;
  logic       use_all;

  // one 1-0-1 toggle per request, low for eight cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_cnt <= 4'h0;
      use_all <= 1'b0;
    end
    else if (pin_cnt != 4'h0)
      pin_cnt <= pin_cnt - 4'h1;
    else if (go_all || go_one)
    begin
      pin_cnt <= 4'h8;
      use_all <= go_all;
    end
  end

  // only one pin is toggled at any time
  assign replay_all_input    = !(pin_cnt != 4'h0 && use_all);
  assign replay_single_input = !(pin_cnt != 4'h0 && !use_all);

  // each command keeps the motor busy for five cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mv_cnt <= 4'h0;
    else if (cmd_valid)
      mv_cnt <= 4'h5;
    else if (mv_cnt != 4'h0)
      mv_cnt <= mv_cnt - 4'h1;
  end

  assign motor_moving = mv_cnt != 4'h0;
  assign cmd_done     = mv_cnt == 4'h1;
endmodule

// *** verif/tb_teach_replay_voltage_follow.sv ***
`timescale 1ns/1ps
`define CHK(a, b) chk(32'(a), 32'(b))
module tb_teach_replay_voltage_follow
  import trvf_pkg::*;
;
  logic            clk;
  logic            rst_n;
  logic [4:0]      reg_addr;
  logic [31:0]     reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [31:0]     reg_rdata;
  logic            pin_all;
  logic            pin_one;
  logic            remote_saved;
  logic            remote_store;
  logic            adc_valid;
  logic [9:0]      adc_data;
  logic            cmd_valid;
  logic [15:0]     cmd_value;
  logic            cmd_done;
  logic            motor_moving;
  logic            busy_ready;
  logic [15:0]     max_rate;
  logic            stop_power;
  trvf_follow_type follow;
  logic            go_all;
  logic            go_one;
  logic [15:0]     cmds[$];
  logic [31:0]     d;
  int              mismatches;
  int              total_checks;
  int              cyc;

  trvf_top #(.ADC_W(10), .DWELL_CYC(4), .PRO_BUILD(1'b1)) DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .replay_all_input(pin_all), .replay_single_input(pin_one),
    .remote_saved(remote_saved), .remote_store(remote_store),
    .adc_valid(adc_valid), .adc_data(adc_data), .cmd_valid(cmd_valid),
    .cmd_value(cmd_value), .cmd_done(cmd_done), .motor_moving(motor_moving),
    .busy_ready(busy_ready), .max_rate(max_rate), .stop_power(stop_power),
    .follow(follow));

  trvf_host_model partner (
    .clk(clk), .rst_n(rst_n), .go_all(go_all), .go_one(go_one),
    .cmd_valid(cmd_valid), .cmd_done(cmd_done), .motor_moving(motor_moving),
    .replay_all_input(pin_all), .replay_single_input(pin_one));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always @(posedge clk)
    if (cmd_valid === 1'b1)
      cmds.push_back(cmd_value);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pulse(input logic all);
    int n;
    @(posedge clk);
    go_all <= all;
    go_one <= !all;
    @(posedge clk);
    go_all <= 1'b0;
    go_one <= 1'b0;
    repeat (8) @(posedge clk);
    n = 0;
    while (busy_ready !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(busy_ready, 1'b1);
  endtask

  task automatic q_chk(input int n, input logic [15:0] e0, input logic [15:0] e1);
    `CHK(cmds.size(), n);
    if (n > 0 && cmds.size() > 0)
      `CHK(cmds[0], e0);
    if (n > 1 && cmds.size() > 1)
      `CHK(cmds[1], e1);
    cmds.delete();
  endtask

  task automatic adc(input logic [9:0] v);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_data  <= v;
    @(posedge clk);
    adc_valid <= 1'b0;
    #1;
    `CHK(follow.valid, 1'b1);
  endtask

  task automatic rst(input logic s);
    @(posedge clk);
    remote_saved <= s;
    rst_n        <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(REG_STATUS);
    `CHK(d[2:1], 2'h0);
    `CHK(busy_ready, 1'b1);
    `CHK(max_rate, 16'h0190);
    `CHK(stop_power, 1'b0);
  endtask

  task automatic t_teach();
    wr(REG_MAXRATE, 32'h0000_0100);
    wr(REG_CTRL, 32'h0000_0010);
    `CHK(max_rate, 16'h0100);
    wr(REG_CTRL, 32'h0000_0012);
    wr(REG_COUNT, 32'h0);
    wr(REG_TEACH, 32'h0000_1234);
    wr(REG_TEACH, 32'h0001_0002);
    wr(REG_TEACH, 32'h0000_5678);
    rd(REG_COUNT);
    `CHK(d[4:0], 5'h03);
    wr(REG_CTRL, 32'h0000_0010);
  endtask

  task automatic t_soft();
    wr(REG_REPLAY, 32'h0000_0002);
    pulse(1'b0);
    q_chk(1, 16'h1234, 16'h0);
    // software replay-all runs every entry from the pointer and comes back to it
    wr(REG_REPLAY, 32'h0000_0001);
    pulse(1'b1);
    q_chk(2, 16'h5678, 16'h1234);
  endtask

  task automatic t_pins();
    wr(REG_CTRL, 32'h0000_0013);
    `CHK(remote_store, 1'b1);
    pulse(1'b0);
    q_chk(0, 16'h0, 16'h0);
    pulse(1'b0);
    q_chk(1, 16'h5678, 16'h0);
    pulse(1'b0);
    q_chk(1, 16'h1234, 16'h0);
    pulse(1'b1);
    q_chk(2, 16'h5678, 16'h1234);
    rd(REG_STATUS);
    `CHK(d[20:16], 5'h01);
  endtask

  task automatic t_volt();
    wr(REG_CTRL, 32'h0000_0010);
    wr(REG_CTRL, 32'h0000_0015);
    adc(10'h3ff);
    `CHK(follow.target, 16'sd149);
    wr(REG_CTRL, 32'h0000_0019);
    adc(10'h3ff);
    `CHK(follow.target, 16'sd599);
    wr(REG_CTRL, 32'h0000_001d);
    adc(10'h000);
    `CHK(follow.speed, 17'sd256);
    adc(10'h3ff);
    `CHK(follow.speed, -17'sd256);
    adc(10'h200);
    `CHK(follow.speed, 17'sd0);
    `CHK(stop_power, 1'b1);
  endtask

  task automatic t_full();
    wr(REG_CTRL, 32'h0000_0012);
    wr(REG_COUNT, 32'h0);
    for (int i = 0; i < 26; i++)
      wr(REG_TEACH, 32'h100 + 32'(i));
    rd(REG_COUNT);
    `CHK(d[4:0], 5'h19);
    wr(REG_CTRL, 32'h0000_0013);
    pulse(1'b1);
    `CHK(cmds.size(), 25);
    for (int i = 0; i < 25 && i < cmds.size(); i++)
      `CHK(cmds[i], 16'h100 + 16'(i));
    cmds.delete();
  endtask

  task automatic t_rst();
    wr(REG_CTRL, 32'h0000_0012);
    rst(1'b0);
    rd(REG_STATUS);
    `CHK(d[2:1], 2'h0);
    `CHK(max_rate, 16'h0190);
    `CHK(stop_power, 1'b0);
    rst(1'b1);
    `CHK(remote_store, 1'b1);
    pulse(1'b0);
    q_chk(0, 16'h0, 16'h0);
    rd(REG_COUNT);
    `CHK(d[4:0], 5'h00);
  endtask

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 5'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    remote_saved = 1'b0;
    adc_valid = 1'b0;
    adc_data = 10'h0;
    go_all = 1'b0;
    go_one = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_teach();
    t_soft();
    t_pins();
    t_volt();
    t_full();
    t_rst();
    stop_test();
  end
endmodule
